// ===== common/mam_pkg.sv
// constants, types and the baud table shared by the multiplexer core and its line units
package mam_pkg;
	localparam int MAM_LINES = 8;
	localparam int MAM_FIFO_DEPTH = 64;
	localparam int MAM_ALARM_COUNT = 16;
	localparam int MAM_CLK_HZ = 25_000_000;
	localparam int MAM_CLK_KHZ = 25_000;
	localparam int MAM_OSC_KHZ = 5_068;
	localparam int MAM_CNT_W = 20;
	localparam logic [2:0] MAM_IRQ_LEVEL = 3'h5;
	localparam logic [2:0] MAM_IRQ_LEVEL_MIN = 3'h4;
	localparam logic [1:0] MAM_LAST_PHASE = 2'h3;
	// word indices of the four bus addresses
	localparam logic [1:0] MAM_REG_CSR = 2'h0;
	localparam logic [1:0] MAM_REG_RBUF_LPR = 2'h1;
	localparam logic [1:0] MAM_REG_TCR = 2'h2;
	localparam logic [1:0] MAM_REG_MSR_TDR = 2'h3;
	// control/status bit positions
	localparam int MAM_CSR_SCAN = 4;
	localparam int MAM_CSR_ALARM_EN = 5;
	localparam int MAM_CSR_RX_IE = 6;
	localparam int MAM_CSR_RECEIVE_DONE_IRQ = 7;
	localparam int MAM_CSR_TLINE = 8;
	localparam int MAM_CSR_ALARM = 13;
	localparam int MAM_CSR_TX_IE = 14;
	localparam int MAM_CSR_TRANSMIT_READY_IRQ = 15;
	// line parameter write fields
	localparam int MAM_LPR_LINE = 0;
	localparam int MAM_LPR_RATE = 3;
	localparam int MAM_LPR_RXEN = 7;
	localparam int MAM_RBUF_VALID = 15;
	localparam logic [3:0] MAM_RATE_RST = 4'he;
	localparam logic [7:0] MAM_VEC_TX_OFS = 8'h04;

	typedef struct packed {
		logic [2:0] line;
		logic [7:0] ch;
	} mam_rx_entry_s;

	typedef enum logic [0:0] {
		MAM_SCAN = 1'b0,
		MAM_HOLD = 1'b1
	} mam_scan_e;

	// clock cycles per bit; table holds twice the baud so 134.5 stays exact
	function automatic logic [MAM_CNT_W-1:0] mam_bit_cycles(input logic [3:0] rate);
		int twice;
		twice = 19200;
		case (rate)
			4'h0: twice = 100;
			4'h1: twice = 150;
			4'h2: twice = 220;
			4'h3: twice = 269;
			4'h4: twice = 300;
			4'h5: twice = 600;
			4'h6: twice = 1200;
			4'h7: twice = 2400;
			4'h8: twice = 3600;
			4'h9: twice = 4000;
			4'ha: twice = 4800;
			4'hb: twice = 7200;
			4'hc: twice = 9600;
			4'hd: twice = 14400;
			default: twice = 19200;
		endcase
		return MAM_CNT_W'((2 * MAM_CLK_HZ) / twice);
	endfunction
endpackage

// ===== design/mam_line_uart.sv
// one asynchronous serial line: 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
module mam_line_uart import mam_pkg::*; (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [MAM_CNT_W-1:0] bit_cycles_i,
	input wire logic rx_en_i,
	input wire logic rxd_i,
	input wire logic rx_ack_i,
	input wire logic tx_load_i,
	input wire logic [7:0] tx_data_i,
	output logic txd_o,
	output logic tx_idle_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o
);
	logic [MAM_CNT_W-1:0] tx_cnt_r;
	logic [9:0] tx_sh_r;
	logic [3:0] tx_bits_r;
	logic [MAM_CNT_W-1:0] rx_cnt_r;
	logic [7:0] rx_sh_r;
	logic [3:0] rx_bits_r;
	logic rx_valid_r;
	logic [7:0] rx_data_r;

	assign txd_o = tx_sh_r[0];
	assign tx_idle_o = (tx_bits_r == 4'h0);
	assign rx_valid_o = rx_valid_r;
	assign rx_data_o = rx_data_r;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tx_sh_r <= 10'h3ff;
			tx_bits_r <= 4'h0;
			tx_cnt_r <= '0;
		end else if (tx_load_i && tx_idle_o) begin
			tx_sh_r <= {1'b1, tx_data_i, 1'b0};
			tx_bits_r <= 4'ha;
			tx_cnt_r <= bit_cycles_i;
		end else if (!tx_idle_o) begin
			if (tx_cnt_r <= 1) begin
				tx_sh_r <= {1'b1, tx_sh_r[9:1]};
				tx_bits_r <= tx_bits_r - 4'h1;
				tx_cnt_r <= bit_cycles_i;
			end else begin
				tx_cnt_r <= tx_cnt_r - 1'b1;
			end
		end
	end

	// a start bit is rechecked at mid-bit so glitches do not frame a character
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !rx_en_i) begin
			rx_bits_r <= 4'h0;
			rx_cnt_r <= '0;
			rx_sh_r <= 8'h00;
		end else if (rx_bits_r == 4'h0) begin
			if (!rxd_i) begin
				rx_bits_r <= 4'ha;
				rx_cnt_r <= bit_cycles_i >> 1;
			end
		end else if (rx_cnt_r <= 1) begin
			rx_cnt_r <= bit_cycles_i;
			rx_bits_r <= (rx_bits_r == 4'ha && rxd_i) ? 4'h0 : rx_bits_r - 4'h1;
			if (rx_bits_r != 4'ha && rx_bits_r != 4'h1)
				rx_sh_r <= {rxd_i, rx_sh_r[7:1]};
		end else begin
			rx_cnt_r <= rx_cnt_r - 1'b1;
		end
	end

	// a new character wins over an acknowledge in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !rx_en_i) begin
			rx_valid_r <= 1'b0;
			rx_data_r <= 8'h00;
		end else if (rx_bits_r == 4'h1 && rx_cnt_r <= 1 && rxd_i) begin
			rx_valid_r <= 1'b1;
			rx_data_r <= rx_sh_r;
		end else if (rx_ack_i) begin
			rx_valid_r <= 1'b0;
		end
	end
endmodule

// ===== design/mam_mux_core.sv
// control core of the eight-line asynchronous multiplexer: bus decode, scanner, fifo, interrupts
//
// What this block does
// - no modem interrupts; only receive and transmit
// - interrupt level 5 by default, 4/6/7 optional
// - one rate per line for both directions
// - receiver enable per line, disabled adds nothing
// - scanner visits lines in turn, strobes data
// - scan steps from 5.068 MHz four-phase clock
// - shared 64-entry receive fifo
// - four addresses give six 16-bit registers
// - two addresses: read and write differ
// - some registers byte-writable, others word only
// - base address match asserts register strobes
// - independent serial converter on every line
// - interrupt request follows bus grant handshake
// - receive done when fifo output holds character
// - alarm after 16 entries, reread rearms, masks done
// - transmit ready when scanner finds idle transmitter
// - fifteen rates, 50 to 9600 baud
`timescale 1ns/1ps
module mam_mux_core import mam_pkg::*; #(
	parameter int LINES = MAM_LINES,
	parameter int FIFO_DEPTH = MAM_FIFO_DEPTH,
	parameter int ALARM_COUNT = MAM_ALARM_COUNT,
	parameter logic [2:0] IRQ_LEVEL = MAM_IRQ_LEVEL,
	parameter logic [15:0] BASE_ADDR = 16'h1000,
	parameter logic [7:0] VEC_BASE = 8'h80
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic bus_rd_i,
	input wire logic bus_wr_i,
	input wire logic bus_byte_i,
	input wire logic [15:0] bus_wdata_i,
	output logic [15:0] bus_rdata_o,
	output logic bus_ack_o,
	output logic irq_req_o,
	output logic [2:0] irq_level_o,
	input wire logic irq_grant_i,
	output logic [7:0] irq_vec_o,
	output logic irq_vec_valid_o,
	input wire logic [LINES-1:0] rxd_i,
	output logic [LINES-1:0] txd_o
);
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int LW = $clog2(LINES);

	////////////////////////////////////////////////////////////////////////////////
	logic [15:0] rdata_r;
	logic ack_r;
	logic scan_en_r, alarm_en_r, rx_ie_r, tx_ie_r;
	logic [3:0] rate_r [LINES];
	logic [LINES-1:0] rxen_r, txen_r;
	logic [14:0] acc_r;
	logic [1:0] phase_r;
	logic [LW-1:0] line_r, tline_r;
	mam_scan_e scan_st_r, scan_st_nxt;
	logic transmit_ready_irq_r;
	mam_rx_entry_s mem [FIFO_DEPTH];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0] cnt_r;
	logic [4:0] alm_cnt_r;
	logic alarm_r;
	logic irq_req_r, rx_svc_r, tx_svc_r, vec_valid_r;
	logic [7:0] vec_r;
	logic [2:0] level_r;
	logic [LINES-1:0] tx_idle, rx_valid, rx_ack;
	// declared here because the line units read them before the scanner section
	logic step, sel_rx;
	logic [7:0] rx_data [LINES];

	////////////////////////////////////////////////////////////////////////////////
	// bus decode
	wire hit = (bus_addr_i[15:3] == BASE_ADDR[15:3]);
	wire [1:0] idx = bus_addr_i[2:1];
	wire wr = hit && bus_wr_i;
	wire rd = hit && bus_rd_i;
	wire wr_csr = wr && idx == MAM_REG_CSR;
	wire wr_lpr = wr && idx == MAM_REG_RBUF_LPR && !bus_byte_i;
	wire wr_tcr = wr && idx == MAM_REG_TCR;
	wire wr_tdr = wr && idx == MAM_REG_MSR_TDR && !bus_byte_i;
	wire rd_rbuf = rd && idx == MAM_REG_RBUF_LPR;
	// byte writes land on the lane that the odd address picks
	wire lo_we = !bus_byte_i || !bus_addr_i[0];
	wire hi_we = !bus_byte_i || bus_addr_i[0];
	wire [LW-1:0] lpr_line = bus_wdata_i[MAM_LPR_LINE +: LW];

	wire fifo_empty = (cnt_r == '0);
	wire fifo_full = (cnt_r == (AW+1)'(FIFO_DEPTH));
	mam_rx_entry_s head;
	assign head = mem[rp_r];
	wire pop = rd_rbuf && !fifo_empty;

	logic [15:0] csr_val, rbuf_val, tcr_val, msr_val, rd_val;
	always_comb begin
		csr_val = 16'h0000;
		csr_val[MAM_CSR_SCAN] = scan_en_r;
		csr_val[MAM_CSR_ALARM_EN] = alarm_en_r;
		csr_val[MAM_CSR_RX_IE] = rx_ie_r;
		csr_val[MAM_CSR_RECEIVE_DONE_IRQ] = !fifo_empty;
		csr_val[MAM_CSR_TLINE +: LW] = tline_r;
		csr_val[MAM_CSR_ALARM] = alarm_r;
		csr_val[MAM_CSR_TX_IE] = tx_ie_r;
		csr_val[MAM_CSR_TRANSMIT_READY_IRQ] = transmit_ready_irq_r;
		rbuf_val = 16'h0000;
		rbuf_val[MAM_RBUF_VALID] = !fifo_empty;
		rbuf_val[10:0] = fifo_empty ? 11'h000 : head;
		tcr_val = 16'h0000;
		tcr_val[LINES-1:0] = txen_r;
		msr_val = 16'h0000;
		msr_val[LINES-1:0] = tx_idle;
		msr_val[8 +: LINES] = rxen_r;
	end
	assign rd_val = (idx == MAM_REG_CSR) ? csr_val :
		(idx == MAM_REG_RBUF_LPR) ? rbuf_val :
		(idx == MAM_REG_TCR) ? tcr_val : msr_val;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ack_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			ack_r <= rd || wr;
			rdata_r <= rd ? rd_val : 16'h0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			scan_en_r <= 1'b0;
			alarm_en_r <= 1'b0;
			rx_ie_r <= 1'b0;
			tx_ie_r <= 1'b0;
			txen_r <= '0;
		end else begin
			if (wr_csr && lo_we) begin
				scan_en_r <= bus_wdata_i[MAM_CSR_SCAN];
				alarm_en_r <= bus_wdata_i[MAM_CSR_ALARM_EN];
				rx_ie_r <= bus_wdata_i[MAM_CSR_RX_IE];
			end
			if (wr_csr && hi_we)
				tx_ie_r <= bus_wdata_i[MAM_CSR_TX_IE];
			if (wr_tcr && lo_we)
				txen_r <= bus_wdata_i[LINES-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// line units
	for (genvar g = 0; g < LINES; g++) begin : g_line
		always_ff @(posedge clk_i) begin
			if (!rstn_i) begin
				rate_r[g] <= MAM_RATE_RST;
				rxen_r[g] <= 1'b0;
			end else if (wr_lpr && lpr_line == LW'(g)) begin
				rate_r[g] <= bus_wdata_i[MAM_LPR_RATE +: 4];
				rxen_r[g] <= bus_wdata_i[MAM_LPR_RXEN];
			end
		end
		assign rx_ack[g] = step && sel_rx && line_r == LW'(g);
		mam_line_uart u_line (
			.clk_i(clk_i),
			.rstn_i(rstn_i),
			.bit_cycles_i(mam_bit_cycles(rate_r[g])),
			.rx_en_i(rxen_r[g]),
			.rxd_i(rxd_i[g]),
			.rx_ack_i(rx_ack[g]),
			.tx_load_i(wr_tdr && transmit_ready_irq_r && tline_r == LW'(g)),
			.tx_data_i(bus_wdata_i[7:0]),
			.txd_o(txd_o[g]),
			.tx_idle_o(tx_idle[g]),
			.rx_valid_o(rx_valid[g]),
			.rx_data_o(rx_data[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// scanner: fractional divider stands in for the oscillator at the core clock
	wire [15:0] osc_sum = {1'b0, acc_r} + 16'(MAM_OSC_KHZ);
	wire osc_tick = (osc_sum >= 16'(MAM_CLK_KHZ));
	assign step = osc_tick && phase_r == MAM_LAST_PHASE && scan_en_r;
	assign sel_rx = rx_valid[line_r] && rxen_r[line_r] && !fifo_full;
	wire sel_tx = txen_r[line_r] && tx_idle[line_r] && scan_st_r == MAM_SCAN;
	wire push = step && sel_rx;
	wire transmit_ready_irq_clr = wr_tdr || !txen_r[tline_r];

	always_comb begin
		scan_st_nxt = scan_st_r;
		case (scan_st_r)
			MAM_SCAN: if (step && sel_tx) scan_st_nxt = MAM_HOLD;
			MAM_HOLD: if (transmit_ready_irq_clr) scan_st_nxt = MAM_SCAN;
			default: scan_st_nxt = MAM_SCAN;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			acc_r <= 15'h0000;
			phase_r <= 2'h0;
			line_r <= '0;
			tline_r <= '0;
			scan_st_r <= MAM_SCAN;
			transmit_ready_irq_r <= 1'b0;
		end else begin
			acc_r <= osc_tick ? 15'(osc_sum - 16'(MAM_CLK_KHZ)) : osc_sum[14:0];
			if (osc_tick)
				phase_r <= phase_r + 2'h1;
			scan_st_r <= scan_st_nxt;
			transmit_ready_irq_r <= scan_st_nxt == MAM_HOLD;
			// the scan stalls on a ready transmitter until software feeds it or clears its transmit enable
			if (step && scan_st_r == MAM_SCAN) begin
				if (sel_tx)
					tline_r <= line_r;
				else
					line_r <= line_r + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receive fifo and alarm
	always_ff @(posedge clk_i) begin
		if (push)
			mem[wp_r] <= '{line: line_r, ch: rx_data[line_r]};
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			alm_cnt_r <= 5'h00;
			alarm_r <= 1'b0;
		end else begin
			wp_r <= wp_r + AW'(push);
			rp_r <= rp_r + AW'(pop);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
			// a read rearms the alarm, but a push in that cycle still counts
			if (rd_rbuf) begin
				alm_cnt_r <= 5'(push);
				alarm_r <= 1'b0;
			end else if (push && !alarm_r) begin
				alm_cnt_r <= alm_cnt_r + 5'h01;
			end
			if (push && !alarm_r && alm_cnt_r == 5'(ALARM_COUNT - 1))
				alarm_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupts: only receive and transmit conditions exist
	wire receive_done_irq = !fifo_empty && rx_ie_r && !alarm_en_r;
	wire fifo_alarm_irq = alarm_r && rx_ie_r && alarm_en_r;
	wire transmit_ready_irq = transmit_ready_irq_r && tx_ie_r;
	wire rx_cond = receive_done_irq || fifo_alarm_irq;
	wire rx_want = rx_cond && !rx_svc_r;
	wire tx_want = transmit_ready_irq && !tx_svc_r;
	wire grant = irq_grant_i && irq_req_r;
	wire [2:0] lvl = (IRQ_LEVEL >= MAM_IRQ_LEVEL_MIN) ? IRQ_LEVEL : MAM_IRQ_LEVEL;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			irq_req_r <= 1'b0;
			rx_svc_r <= 1'b0;
			tx_svc_r <= 1'b0;
			vec_r <= 8'h00;
			vec_valid_r <= 1'b0;
			level_r <= MAM_IRQ_LEVEL;
		end else begin
			level_r <= lvl;
			vec_valid_r <= grant;
			irq_req_r <= (rx_want || tx_want) && !grant;
			if (grant)
				vec_r <= rx_want ? VEC_BASE : VEC_BASE + MAM_VEC_TX_OFS;
			// with the alarm disabled, each new character at the fifo output asks again
			if (grant && rx_want)
				rx_svc_r <= 1'b1;
			else if (!rx_cond || pop)
				rx_svc_r <= 1'b0;
			if (grant && !rx_want)
				tx_svc_r <= 1'b1;
			else if (!transmit_ready_irq)
				tx_svc_r <= 1'b0;
		end
	end

	assign bus_rdata_o = rdata_r;
	assign bus_ack_o = ack_r;
	assign irq_req_o = irq_req_r;
	assign irq_level_o = level_r;
	assign irq_vec_o = vec_r;
	assign irq_vec_valid_o = vec_valid_r;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence alarm_trip_s;
		push && !rd_rbuf && !alarm_r && alm_cnt_r == 5'(ALARM_COUNT - 1);
	endsequence

	irq_level_a: assert property (##1 irq_level_o == lvl && irq_level_o >= 3'h4)
		else $error("interrupt level wrong");
	rx_gate_a: assert property (push |-> rxen_r[line_r] && rx_valid[line_r])
		else $error("disabled line pushed");
	scan_step_a: assert property (step && scan_st_r == MAM_SCAN && !sel_tx
		|=> line_r == $past(line_r) + 1'b1)
		else $error("scanner did not advance");
	phase_seq_a: assert property (osc_tick |=> phase_r == $past(phase_r) + 2'h1)
		else $error("phase did not advance");
	fifo_bound_a: assert property (cnt_r <= (AW+1)'(FIFO_DEPTH) && !(push && fifo_full))
		else $error("fifo overrun");
	alarm_fire_a: assert property (alarm_trip_s |=> alarm_r)
		else $error("alarm missed");
	receive_done_irq_mask_a: assert property (alarm_en_r |-> !receive_done_irq)
		else $error("done not masked");
	word_only_a: assert property (wr && bus_byte_i && idx == MAM_REG_RBUF_LPR
		|=> $stable(rxen_r))
		else $error("byte write changed line params");
	bus_ack_a: assert property ((rd || wr) |=> bus_ack_o ##1 !bus_ack_o || $past(rd || wr))
		else $error("ack timing");
	transmit_ready_irq_hold_a: assert property ($rose(transmit_ready_irq_r) |-> tx_idle[tline_r] && txen_r[tline_r])
		else $error("ready on busy line");
	grant_vec_a: assert property (grant |=> irq_vec_valid_o && !irq_req_o)
		else $error("grant not answered");
endmodule

// ===== verif/mam_term_model.sv
// serial terminal model: drives all eight receive lines and decodes one transmit line
`timescale 1ns/1ps
module mam_term_model #(
	parameter int BIT = 2604
) (
	input wire logic clk_i,
	input wire logic [7:0] txd_i,
	output logic [7:0] rxd_o
);
	// lines rest at mark between frames, like a real idle terminal
	initial rxd_o = 8'hff;

	////////////////////////////////////////////////////////////////////////
	// one 8n1 frame on every line at once, char = base + line, lsb first
	task automatic send_all(input logic [7:0] base);
		logic [9:0] fr [8];
		for (int l = 0; l < 8; l++) fr[l] = {1'b1, base + 8'(l), 1'b0};
		for (int b = 0; b < 10; b++) begin
			for (int l = 0; l < 8; l++) rxd_o[l] <= fr[l][b];
			repeat (BIT) @(posedge clk_i);
		end
	endtask

	// samples mid-bit; ok stays low on a missing start or a bad stop bit
	task automatic recv(input int l, output logic [7:0] ch, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		ch = 8'h00;
		while (txd_i[l] !== 1'b0 && n < 4 * BIT) begin
			@(posedge clk_i);
			n++;
		end
		if (n < 4 * BIT) begin
			repeat (BIT + BIT / 2) @(posedge clk_i);
			for (int b = 0; b < 8; b++) begin
				ch[b] = txd_i[l];
				repeat (BIT) @(posedge clk_i);
			end
			ok = (txd_i[l] === 1'b1);
		end
	endtask
endmodule

// ===== verif/multiline_async_mux_core_tb.sv
// self-checking bench for the multiplexer core
`timescale 1ns/1ps
module multiline_async_mux_core_tb import mam_pkg::*; ();
	localparam logic [15:0] A_CSR = 16'h1000;
	localparam logic [15:0] A_RBUF = 16'h1002;
	localparam logic [15:0] A_TCR = 16'h1004;
	localparam logic [15:0] A_MSR = 16'h1006;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [15:0] bus_addr_i = 16'h0000;
	logic bus_rd_i = 1'b0;
	logic bus_wr_i = 1'b0;
	logic bus_byte_i = 1'b0;
	logic [15:0] bus_wdata_i = 16'h0000;
	logic irq_grant_i = 1'b0;
	logic [15:0] bus_rdata_o;
	logic bus_ack_o;
	logic irq_req_o;
	logic irq_vec_valid_o;
	logic [2:0] irq_level_o;
	logic [7:0] irq_vec_o;
	logic [7:0] rxd_i;
	logic [7:0] txd_o;
	int n_fail = 0;
	int checks_done = 0;

	always #20 clk_i = ~clk_i;

	mam_mux_core uut (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.bus_addr_i(bus_addr_i),
		.bus_rd_i(bus_rd_i),
		.bus_wr_i(bus_wr_i),
		.bus_byte_i(bus_byte_i),
		.bus_wdata_i(bus_wdata_i),
		.bus_rdata_o(bus_rdata_o),
		.bus_ack_o(bus_ack_o),
		.irq_req_o(irq_req_o),
		.irq_level_o(irq_level_o),
		.irq_grant_i(irq_grant_i),
		.irq_vec_o(irq_vec_o),
		.irq_vec_valid_o(irq_vec_valid_o),
		.rxd_i(rxd_i),
		.txd_o(txd_o)
	);

	mam_term_model term (
		.clk_i(clk_i),
		.txd_i(txd_o),
		.rxd_o(rxd_i)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// one request pulse; byte accesses can go to any register, word-only ones included
	task automatic bus(input logic wr, input logic bt, input logic [15:0] a,
			input logic [15:0] wd, input logic ack, output logic [15:0] rd);
		@(posedge clk_i);
		bus_wr_i <= wr;
		bus_rd_i <= !wr;
		bus_byte_i <= bt;
		bus_addr_i <= a;
		bus_wdata_i <= wd;
		@(posedge clk_i);
		bus_wr_i <= 1'b0;
		bus_rd_i <= 1'b0;
		#1;
		rd = bus_rdata_o;
		check(bus_ack_o, ack);
	endtask

	task automatic wr_w(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] x;
		bus(1'b1, 1'b0, a, d, 1'b1, x);
	endtask

	task automatic rd_w(input logic [15:0] a, output logic [15:0] d);
		bus(1'b0, 1'b0, a, 16'h0000, 1'b1, d);
	endtask

	// waits for a request, grants it and checks the vector handed back
	task automatic irq_take(input logic [7:0] vec);
		int n;
		n = 0;
		while (irq_req_o !== 1'b1 && n < 2000) begin
			tick(1);
			n++;
		end
		check(irq_req_o, 1'b1);
		if (irq_req_o !== 1'b1) stop_test();
		@(posedge clk_i);
		irq_grant_i <= 1'b1;
		@(posedge clk_i);
		irq_grant_i <= 1'b0;
		#1;
		check(irq_vec_valid_o, 1'b1);
		check(irq_vec_o, vec);
		check(irq_req_o, 1'b0);
	endtask

	// frames arrive far apart, so entry i belongs to frame i/8; ends on an empty read
	task automatic drain(input int n, input logic [7:0] base, output logic [15:0] mask);
		logic [15:0] d;
		mask = 16'h0000;
		for (int i = 0; i < n; i++) begin
			rd_w(A_RBUF, d);
			check(d[MAM_RBUF_VALID], 1'b1);
			check(d[7:0], base + 8'(16 * (i / 8)) + 8'(d[10:8]));
			mask[4'(d[10:8]) + 4'(8 * (i / 8))] = 1'b1;
		end
		rd_w(A_RBUF, d);
		check(d, 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [15:0] d;
		check(irq_level_o, MAM_IRQ_LEVEL);
		check(txd_o, 8'hff);
		rd_w(A_CSR, d);
		check(d, 16'h0000);
		rd_w(A_MSR, d);
		check(d, 16'h00ff);
		bus(1'b0, 1'b0, 16'h2000, 16'h0000, 1'b0, d);
		check(d, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_regs;
		logic [15:0] d;
		wr_w(A_TCR, 16'h5a5a);
		rd_w(A_TCR, d);
		check(d, 16'h005a);
		wr_w(A_TCR, 16'h0000);
		bus(1'b1, 1'b1, A_CSR + 16'h0001, 16'h4000, 1'b1, d);
		rd_w(A_CSR, d);
		check(d, 16'h4000);
		wr_w(A_CSR, 16'h0000);
		bus(1'b1, 1'b1, A_RBUF, 16'h00f0, 1'b1, d);
		rd_w(A_MSR, d);
		check(d, 16'h00ff);
		wr_w(A_MSR, 16'h0055);
		for (int l = 0; l < 8; l++) wr_w(A_RBUF, 16'h00f0 | 16'(l));
		rd_w(A_MSR, d);
		check(d, 16'hffff);
		rd_w(A_RBUF, d);
		check(d, 16'h0000);
		tick(300);
		check(txd_o, 8'hff);
		$display("test registers done");
	endtask

	// sixteen characters over two frames on all lines raise the alarm
	task automatic t_alarm;
		logic [15:0] d;
		logic [15:0] m;
		wr_w(A_CSR, 16'h0070);
		term.send_all(8'h30);
		tick(400);
		check(irq_req_o, 1'b0);
		rd_w(A_CSR, d);
		check(d & 16'ha080, 16'h0080);
		term.send_all(8'h40);
		tick(400);
		rd_w(A_CSR, d);
		check(d & 16'h2080, 16'h2080);
		irq_take(8'h80);
		drain(16, 8'h30, m);
		check(m, 16'hffff);
		rd_w(A_CSR, d);
		check(d & 16'h2080, 16'h0000);
		$display("test receive alarm done");
	endtask

	// transmit on line 0 while line 7 has its receiver switched off
	task automatic t_tx;
		logic [15:0] d;
		logic [15:0] m;
		logic [7:0] ch;
		logic ok;
		wr_w(A_TCR, 16'h0001);
		wr_w(A_CSR, 16'h4070);
		irq_take(8'h84);
		rd_w(A_CSR, d);
		check(d & 16'h8700, 16'h8000);
		wr_w(A_RBUF, 16'h0077);
		wr_w(A_MSR, 16'h00a5);
		fork
			term.send_all(8'h50);
			term.recv(0, ch, ok);
		join
		check(ok, 1'b1);
		check(ch, 8'ha5);
		tick(400);
		drain(7, 8'h50, m);
		check(m, 16'h007f);
		$display("test transmit done");
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		tick(1);
		t_reset();
		t_regs();
		t_alarm();
		t_tx();
		stop_test();
	end

	// three frames at 9600 baud need about 80k cycles; this cuts a hang short
	initial begin
		repeat (95000) @(posedge clk_i);
		n_fail++;
		stop_test();
	end
endmodule
